// ---- design/sstsup_pkg.sv ----
package sstsup_pkg;

   // Clock and time figures
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned MS_CYC        = CLK_HZ / 1000;
   localparam int unsigned HOLD_ENTER_MS = 2000;
   localparam int unsigned HOLD_NEXT_MS  = 1000;
   localparam int unsigned LOCKOUT_MS    = 10000;
   localparam int unsigned STEP_MS       = 100;
   localparam int unsigned BRAKE_MS      = 50;

   localparam logic [25:0] HOLD_ENTER_CYC_DEF = 26'(HOLD_ENTER_MS * MS_CYC);
   localparam logic [25:0] HOLD_NEXT_CYC_DEF  = 26'(HOLD_NEXT_MS * MS_CYC);
   localparam logic [27:0] LOCKOUT_CYC_DEF    = 28'(LOCKOUT_MS * MS_CYC);
   localparam logic [20:0] STEP_CYC_DEF       = 21'(STEP_MS * MS_CYC);
   localparam logic [27:0] BRAKE_CYC_DEF      = 28'(BRAKE_MS * MS_CYC);

   // Register offsets
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_DURATION = 8'h04;
   localparam logic [7:0] ADDR_LEVEL    = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;

   // Field positions and limits
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned STAT_MENU_LSB   = 4;
   localparam int unsigned STAT_RUN_LSB    = 8;
   localparam int unsigned STAT_SPEED_LSB  = 16;
   localparam logic [6:0]  DUR_MAX         = 7'h63;
   localparam logic [3:0]  LEVEL_MAX       = 4'h9;
   localparam logic [6:0]  FULL_PCT        = 7'h64;

   // Reset values
   localparam logic       ENABLE_RST   = 1'b1;
   localparam logic [6:0] DURATION_RST = 7'h00;
   localparam logic [3:0] LEVEL_RST    = 4'h0;

   // Fault codes shown on the display
   localparam logic [3:0] CODE_NONE             = 4'h0;
   localparam logic [3:0] UNDERVOLTAGE_CODE     = 4'h3;
   localparam logic [3:0] OVERTEMP_CODE         = 4'h4;
   localparam logic [3:0] STALL_CODE            = 4'h5;
   localparam logic [3:0] PUSH_PLATE_CODE       = 4'h7;
   localparam logic [3:0] BRAKE_FAULT_CODE      = 4'h8;
   localparam logic [3:0] MEMORY_FAULT_CODE     = 4'h9;

   // Interrupt bits
   localparam int unsigned IRQ_W       = 4;
   localparam int unsigned IRQ_FAULT   = 0;
   localparam int unsigned IRQ_RECOVER = 1;
   localparam int unsigned IRQ_START   = 2;
   localparam int unsigned IRQ_MENU    = 3;

   typedef enum logic [2:0] {RUN_IDLE, RUN_ACTIVE, RUN_BRAKE, RUN_FLT_TIMED,
                             RUN_FLT_WAIT} sstsup_run_e;
   typedef enum logic [1:0] {MENU_NORMAL, MENU_DURATION, MENU_SPEED} sstsup_menu_e;
   typedef enum logic [2:0] {DISP_LEVEL, DISP_NO_SLOW, DISP_DURATION_MENU,
                             DISP_SPEED_MENU, DISP_FAULT} sstsup_disp_e;

   // Reduced speed levels span 30 to 90 percent
   function automatic logic [6:0] level_pct(input logic [3:0] lvl);
      logic [6:0] p;
      p = FULL_PCT;
      case (lvl)
         4'h1: p = 7'h1e;
         4'h2: p = 7'h25;
         4'h3: p = 7'h2d;
         4'h4: p = 7'h34;
         4'h5: p = 7'h3c;
         4'h6: p = 7'h43;
         4'h7: p = 7'h4b;
         4'h8: p = 7'h52;
         4'h9: p = 7'h5a;
         default: p = FULL_PCT;
      endcase
      return p;
   endfunction

endpackage

// ---- design/sstsup_top.sv ----
`timescale 1ns/1ps
module sstsup_top #(
   parameter logic [25:0] HOLD_ENTER_CYC = sstsup_pkg::HOLD_ENTER_CYC_DEF,
   parameter logic [25:0] HOLD_NEXT_CYC  = sstsup_pkg::HOLD_NEXT_CYC_DEF,
   parameter logic [27:0] LOCKOUT_CYC    = sstsup_pkg::LOCKOUT_CYC_DEF,
   parameter logic [20:0] STEP_CYC       = sstsup_pkg::STEP_CYC_DEF,
   parameter logic [27:0] BRAKE_CYC      = sstsup_pkg::BRAKE_CYC_DEF
) (
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   input  wire logic [7:0]               bus_addr,
   input  wire logic [31:0]              bus_wdata,
   input  wire logic                     bus_wr,
   input  wire logic                     bus_rd,
   output logic      [31:0]              bus_rdata,
   output logic                          irq,
   input  wire logic                     trigger_in,
   input  wire logic                     push_plate_rev,
   input  wire logic                     brake_sig_in,
   input  wire logic                     undervolt_in,
   input  wire logic                     overtemp_in,
   input  wire logic                     stall_in,
   input  wire logic                     mem_fail_in,
   input  wire logic                     btn_up,
   input  wire logic                     btn_down,
   output logic                          run_relay,
   output logic                          brake_relay,
   output logic                          reverse_relay,
   output logic                          motor_en,
   output logic                          motor_rev,
   output logic      [6:0]               speed_pct,
   output sstsup_pkg::sstsup_disp_e      disp_mode,
   output logic      [6:0]               disp_value
);
   import sstsup_pkg::*;

   typedef struct packed {
      sstsup_run_e       run;
      sstsup_menu_e      menu;
      logic [3:0]        fault_code;
      logic              dir_at_start;
      logic              trig_prev;
      logic              up_prev;
      logic              dn_prev;
      logic              hold_armed;
      logic [25:0]       hold_cnt;
      logic [27:0]       lock_cnt;
      logic [20:0]       tick_cnt;
      logic [6:0]        elapsed;
      logic [6:0]        duration;
      logic [3:0]        level;
      logic              enable;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_en;
      logic [31:0]       rdata;
      logic              run_o;
      logic              brake_o;
      logic              rev_o;
      logic [6:0]        speed_o;
      sstsup_disp_e      disp_o;
      logic [6:0]        dval_o;
   } sstsup_state_s;

   sstsup_state_s s_r;
   sstsup_state_s s_nxt;

   always_comb
   begin
      logic [IRQ_W-1:0] ev;
      logic [3:0]       tcode;
      logic             start_req;
      logic             both;
      logic             up_press;
      logic             dn_press;
      logic [25:0]      hold_thr;
      logic [31:0]      rd;
      ev        = '0;
      tcode     = CODE_NONE;
      s_nxt     = s_r;
      start_req = trigger_in && !s_r.trig_prev;
      both      = btn_up && btn_down;
      up_press  = btn_up && !s_r.up_prev && !btn_down;
      dn_press  = btn_down && !s_r.dn_prev && !btn_up;
      hold_thr  = (s_r.menu == MENU_NORMAL) ? HOLD_ENTER_CYC : HOLD_NEXT_CYC;
      rd        = 32'h0000_0000;

      s_nxt.trig_prev = trigger_in;
      s_nxt.up_prev   = btn_up;
      s_nxt.dn_prev   = btn_down;

      // Timed faults, highest priority first
      if (undervolt_in)
         tcode = UNDERVOLTAGE_CODE;
      else if (overtemp_in)
         tcode = OVERTEMP_CODE;
      else if (stall_in && s_r.run == RUN_ACTIVE)
         tcode = STALL_CODE;
      else if (mem_fail_in)
         tcode = MEMORY_FAULT_CODE;

      case (s_r.run)
         RUN_IDLE:
         begin
            if (tcode != CODE_NONE)
            begin
               s_nxt.run        = RUN_FLT_TIMED;
               s_nxt.fault_code = tcode;
               s_nxt.lock_cnt   = '0;
               ev[IRQ_FAULT]    = 1'b1;
            end
            else if (start_req && brake_sig_in)
            begin
               s_nxt.run        = RUN_FLT_WAIT;
               s_nxt.fault_code = BRAKE_FAULT_CODE;
               ev[IRQ_FAULT]    = 1'b1;
            end
            else if (start_req && s_r.enable)
            begin
               s_nxt.run          = RUN_ACTIVE;
               s_nxt.dir_at_start = push_plate_rev;
               s_nxt.tick_cnt     = '0;
               s_nxt.elapsed      = '0;
               ev[IRQ_START]      = 1'b1;
            end
         end
         RUN_ACTIVE:
         begin
            if (tcode != CODE_NONE)
            begin
               s_nxt.run        = RUN_FLT_TIMED;
               s_nxt.fault_code = tcode;
               s_nxt.lock_cnt   = '0;
               ev[IRQ_FAULT]    = 1'b1;
            end
            else if (push_plate_rev != s_r.dir_at_start)
            begin
               s_nxt.run        = RUN_FLT_WAIT;
               s_nxt.fault_code = PUSH_PLATE_CODE;
               ev[IRQ_FAULT]    = 1'b1;
            end
            else if (!trigger_in || !s_r.enable)
            begin
               s_nxt.run      = RUN_BRAKE;
               s_nxt.lock_cnt = '0;
            end
            else if (s_r.elapsed < s_r.duration)
            begin
               // Tenth-second ticks pace the slow-start window
               if (s_r.tick_cnt == STEP_CYC - 21'h1)
               begin
                  s_nxt.tick_cnt = '0;
                  s_nxt.elapsed  = s_r.elapsed + 7'h1;
               end
               else
                  s_nxt.tick_cnt = s_r.tick_cnt + 21'h1;
            end
         end
         RUN_BRAKE:
         begin
            if (tcode != CODE_NONE)
            begin
               s_nxt.run        = RUN_FLT_TIMED;
               s_nxt.fault_code = tcode;
               s_nxt.lock_cnt   = '0;
               ev[IRQ_FAULT]    = 1'b1;
            end
            else if (s_r.lock_cnt == BRAKE_CYC - 28'h1)
               s_nxt.run = RUN_IDLE;
            else
               s_nxt.lock_cnt = s_r.lock_cnt + 28'h1;
         end
         RUN_FLT_TIMED:
         begin
            // Lockout runs its full length even if the cause is gone early
            if (s_r.lock_cnt == LOCKOUT_CYC - 28'h1)
            begin
               s_nxt.run        = RUN_IDLE;
               s_nxt.fault_code = CODE_NONE;
               ev[IRQ_RECOVER]  = 1'b1;
            end
            else
               s_nxt.lock_cnt = s_r.lock_cnt + 28'h1;
         end
         RUN_FLT_WAIT:
         begin
            if ((s_r.fault_code == PUSH_PLATE_CODE && push_plate_rev == s_r.dir_at_start)
                || (s_r.fault_code == BRAKE_FAULT_CODE && !brake_sig_in))
            begin
               s_nxt.run        = RUN_IDLE;
               s_nxt.fault_code = CODE_NONE;
               ev[IRQ_RECOVER]  = 1'b1;
            end
         end
         default:
         begin
            s_nxt.run        = RUN_IDLE;
            s_nxt.fault_code = CODE_NONE;
         end
      endcase

      // Two-button hold walks the menus; release rearms it
      if (!both)
      begin
         s_nxt.hold_cnt   = '0;
         s_nxt.hold_armed = 1'b1;
      end
      else if (s_r.hold_armed)
      begin
         if (s_r.hold_cnt == hold_thr - 26'h1)
         begin
            s_nxt.hold_cnt   = '0;
            s_nxt.hold_armed = 1'b0;
            ev[IRQ_MENU]     = 1'b1;
            case (s_r.menu)
               MENU_NORMAL:   s_nxt.menu = MENU_DURATION;
               MENU_DURATION: s_nxt.menu = MENU_SPEED;
               default:       s_nxt.menu = MENU_NORMAL;
            endcase
         end
         else
            s_nxt.hold_cnt = s_r.hold_cnt + 26'h1;
      end

      case (s_r.menu)
         MENU_DURATION:
         begin
            if (up_press && s_r.duration < DUR_MAX)
               s_nxt.duration = s_r.duration + 7'h1;
            else if (dn_press && s_r.duration != 7'h00)
               s_nxt.duration = s_r.duration - 7'h1;
         end
         MENU_SPEED:
         begin
            if (up_press && s_r.level < LEVEL_MAX)
               s_nxt.level = s_r.level + 4'h1;
            else if (dn_press && s_r.level != 4'h0)
               s_nxt.level = s_r.level - 4'h1;
         end
         default:
         begin
         end
      endcase

      // Bus writes override panel edits in the same cycle
      if (bus_wr)
      begin
         case (bus_addr)
            ADDR_CTRL:
               s_nxt.enable = bus_wdata[CTRL_ENABLE_BIT];
            ADDR_DURATION:
               s_nxt.duration = (bus_wdata[31:0] > 32'(DUR_MAX)) ? DUR_MAX
                                : bus_wdata[6:0];
            ADDR_LEVEL:
               s_nxt.level = (bus_wdata[31:0] > 32'(LEVEL_MAX)) ? LEVEL_MAX
                             : bus_wdata[3:0];
            ADDR_IRQ_EN:
               s_nxt.irq_en = bus_wdata[IRQ_W-1:0];
            default:
            begin
            end
         endcase
      end

      // New events win over a clear in the same cycle
      s_nxt.irq_stat = s_r.irq_stat;
      if (bus_wr && bus_addr == ADDR_IRQ_CLR)
         s_nxt.irq_stat = s_r.irq_stat & ~bus_wdata[IRQ_W-1:0];
      s_nxt.irq_stat = s_nxt.irq_stat | ev;

      if (bus_rd)
      begin
         case (bus_addr)
            ADDR_CTRL:     rd[CTRL_ENABLE_BIT] = s_r.enable;
            ADDR_DURATION: rd[6:0] = s_r.duration;
            ADDR_LEVEL:    rd[3:0] = s_r.level;
            ADDR_STATUS:
            begin
               rd[3:0]                  = s_r.fault_code;
               rd[STAT_MENU_LSB +: 2]   = s_r.menu;
               rd[STAT_RUN_LSB +: 3]    = s_r.run;
               rd[STAT_SPEED_LSB +: 7]  = s_r.speed_o;
            end
            ADDR_IRQ_STAT: rd[IRQ_W-1:0] = s_r.irq_stat;
            ADDR_IRQ_EN:   rd[IRQ_W-1:0] = s_r.irq_en;
            default:       rd = 32'h0000_0000;
         endcase
      end
      s_nxt.rdata = rd;

      // Registered outputs follow the next state
      s_nxt.run_o   = (s_nxt.run == RUN_ACTIVE);
      s_nxt.rev_o   = (s_nxt.run == RUN_ACTIVE) && s_nxt.dir_at_start;
      s_nxt.brake_o = (s_nxt.run == RUN_BRAKE) || (s_nxt.run == RUN_FLT_TIMED)
                      || (s_nxt.run == RUN_FLT_WAIT);
      if (s_nxt.run != RUN_ACTIVE)
         s_nxt.speed_o = 7'h00;
      else if (s_nxt.level != 4'h0 && s_nxt.elapsed < s_nxt.duration)
         s_nxt.speed_o = level_pct(s_nxt.level);
      else
         s_nxt.speed_o = FULL_PCT;

      if (s_nxt.fault_code != CODE_NONE)
      begin
         s_nxt.disp_o = DISP_FAULT;
         s_nxt.dval_o = {3'h0, s_nxt.fault_code};
      end
      else if (s_nxt.menu == MENU_DURATION)
      begin
         s_nxt.disp_o = DISP_DURATION_MENU;
         s_nxt.dval_o = s_nxt.duration;
      end
      else if (s_nxt.menu == MENU_SPEED)
      begin
         s_nxt.disp_o = DISP_SPEED_MENU;
         s_nxt.dval_o = {3'h0, s_nxt.level};
      end
      else if (s_nxt.level == 4'h0)
      begin
         s_nxt.disp_o = DISP_NO_SLOW;
         s_nxt.dval_o = 7'h00;
      end
      else
      begin
         s_nxt.disp_o = DISP_LEVEL;
         s_nxt.dval_o = {3'h0, s_nxt.level};
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r            <= '0;
         s_r.run        <= RUN_IDLE;
         s_r.menu       <= MENU_NORMAL;
         s_r.fault_code <= CODE_NONE;
         s_r.hold_armed <= 1'b1;
         s_r.duration   <= DURATION_RST;
         s_r.level      <= LEVEL_RST;
         s_r.enable     <= ENABLE_RST;
         s_r.disp_o     <= DISP_NO_SLOW;
      end
      else
         s_r <= s_nxt;
   end

   assign bus_rdata     = s_r.rdata;
   assign irq           = |(s_r.irq_stat & s_r.irq_en);
   assign run_relay     = s_r.run_o;
   assign brake_relay   = s_r.brake_o;
   assign reverse_relay = s_r.rev_o;
   assign motor_en      = s_r.run_o;
   assign motor_rev     = s_r.rev_o;
   assign speed_pct     = s_r.speed_o;
   assign disp_mode     = s_r.disp_o;
   assign disp_value    = s_r.dval_o;

endmodule

// ---- verif/sstsup_top_properties.sv ----
`timescale 1ns/1ps
module sstsup_checker #(
   parameter logic [25:0] HOLD_ENTER_CYC = sstsup_pkg::HOLD_ENTER_CYC_DEF,
   parameter logic [27:0] LOCKOUT_CYC    = sstsup_pkg::LOCKOUT_CYC_DEF
) (
   input wire logic                     mclk,
   input wire logic                     rst_n,
   input wire logic                     trigger_in,
   input wire logic                     brake_sig_in,
   input wire logic                     undervolt_in,
   input wire logic                     overtemp_in,
   input wire logic                     btn_up,
   input wire logic                     btn_down,
   input wire logic                     run_relay,
   input wire logic                     brake_relay,
   input wire logic                     reverse_relay,
   input wire logic                     motor_en,
   input wire logic                     motor_rev,
   input wire logic      [6:0]          speed_pct,
   input wire sstsup_pkg::sstsup_disp_e disp_mode,
   input wire logic      [6:0]          disp_value
);
   import sstsup_pkg::*;
   logic [27:0] flt_cnt_r;
   logic [25:0] hold_cnt_r;
   logic        flt_on;
   logic        both_held;
   logic        timed_code;
   assign flt_on     = (disp_mode == DISP_FAULT);
   assign both_held  = btn_up && btn_down;
   assign timed_code = disp_value inside {UNDERVOLTAGE_CODE, OVERTEMP_CODE, STALL_CODE,
                                          MEMORY_FAULT_CODE};
   // Counters let long holds and lockouts be checked without huge repetitions
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
      begin
         flt_cnt_r  <= '0;
         hold_cnt_r <= '0;
      end
      else
      begin
         flt_cnt_r  <= flt_on ? flt_cnt_r + 28'h1 : 28'h0;
         hold_cnt_r <= both_held ? hold_cnt_r + 26'h1 : 26'h0;
      end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence run_begin;
      $rose(run_relay);
   endsequence
   sequence up_press;
      $rose(btn_up) && !btn_down;
   endsequence
   chk_run_needs_trigger: assert property (
      run_begin |-> $past(trigger_in) && !$past(brake_relay))
      else $error("run began without a trigger from idle");
   chk_motor_mirrors: assert property (
      motor_en == run_relay && motor_rev == reverse_relay)
      else $error("motor outputs differ from relays");
   chk_rev_only_run: assert property (reverse_relay |-> run_relay)
      else $error("reverse relay without run");
   chk_stop_brakes: assert property ($fell(run_relay) |-> brake_relay)
      else $error("run ended without brake relay");
   chk_uv_fault: assert property (
      undervolt_in && !flt_on |=> flt_on && disp_value == 7'(UNDERVOLTAGE_CODE))
      else $error("undervoltage not shown");
   chk_ot_fault: assert property (
      overtemp_in && !undervolt_in && !flt_on |=> flt_on && disp_value == 7'(OVERTEMP_CODE))
      else $error("overtemperature not shown");
   chk_fault_stops: assert property (
      flt_on |-> !run_relay && speed_pct == 7'h00 && brake_relay)
      else $error("motor not stopped in fault");
   chk_lockout_hold: assert property (
      flt_on && timed_code && flt_cnt_r < LOCKOUT_CYC - 28'h1
      |=> flt_on && $stable(disp_value))
      else $error("lockout ended early");
   chk_lockout_end: assert property (
      flt_on && timed_code && flt_cnt_r == LOCKOUT_CYC - 28'h1 |=> !flt_on)
      else $error("lockout ran long");
   chk_brake_wait: assert property (
      flt_on && disp_value == 7'(BRAKE_FAULT_CODE) && brake_sig_in
      |=> flt_on && $stable(disp_value))
      else $error("brake fault left while brake present");
   chk_menu_enter: assert property (
      both_held && hold_cnt_r == HOLD_ENTER_CYC - 26'h1
      && disp_mode inside {DISP_LEVEL, DISP_NO_SLOW} |=> disp_mode == DISP_DURATION_MENU)
      else $error("duration menu not entered");
   chk_dur_step: assert property (
      (disp_mode == DISP_DURATION_MENU) and up_press
      |=> disp_value == (($past(disp_value) == 7'h63) ? 7'h63 : $past(disp_value) + 7'h01))
      else $error("duration step wrong");
   chk_full_when_off: assert property (
      run_begin and disp_mode == DISP_NO_SLOW |-> speed_pct == FULL_PCT)
      else $error("slow start not disabled");
   chk_idle_no_speed: assert property (!run_relay |-> speed_pct == 7'h00)
      else $error("speed commanded while stopped");
endmodule

// ---- verif/sstsup_tool_model.sv ----
`timescale 1ns/1ps
module sstsup_tool_model (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic motor_en,
   input  wire logic stall_cmd,
   output logic      stall_in
);
   // A rotor can only stall while it is driven
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
         stall_in <= 1'b0;
      else
         stall_in <= stall_cmd && motor_en;
endmodule

// ---- verif/tb_sstsup_top.sv ----
`timescale 1ns/1ps
bind sstsup_top sstsup_checker #(.HOLD_ENTER_CYC(HOLD_ENTER_CYC), .LOCKOUT_CYC(LOCKOUT_CYC))
   sstsup_checker_i (.mclk, .rst_n, .trigger_in, .brake_sig_in, .undervolt_in, .overtemp_in,
      .btn_up, .btn_down, .run_relay, .brake_relay, .reverse_relay, .motor_en, .motor_rev,
      .speed_pct, .disp_mode, .disp_value);
module tb_sstsup_top;
   import sstsup_pkg::*;
   localparam logic [3:0] FCODE [4] = '{UNDERVOLTAGE_CODE, OVERTEMP_CODE, STALL_CODE,
                                        MEMORY_FAULT_CODE};
   logic         mclk, rst_n, bus_wr, bus_rd, irq, trigger_in, push_plate_rev, brake_sig_in;
   logic         undervolt_in, overtemp_in, stall_in, stall_cmd, mem_fail_in, btn_up, btn_down;
   logic         run_relay, brake_relay, reverse_relay, motor_en, motor_rev;
   logic [7:0]   bus_addr;
   logic [31:0]  bus_wdata, bus_rdata, rd_val;
   logic [6:0]   speed_pct, disp_value;
   sstsup_disp_e disp_mode;
   int           err_total, compares;
   // Short counts keep the run small; lockout is 50 cycles, one tenth is 4
   sstsup_top #(.HOLD_ENTER_CYC(26'h14), .HOLD_NEXT_CYC(26'h0a), .LOCKOUT_CYC(28'h32),
      .STEP_CYC(21'h4), .BRAKE_CYC(28'h3)) sstsup_top_i (.mclk, .rst_n, .bus_addr,
      .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .irq, .trigger_in, .push_plate_rev,
      .brake_sig_in, .undervolt_in, .overtemp_in, .stall_in, .mem_fail_in, .btn_up,
      .btn_down, .run_relay, .brake_relay, .reverse_relay, .motor_en, .motor_rev,
      .speed_pct, .disp_mode, .disp_value);
   sstsup_tool_model sstsup_tool_model_i (.mclk, .rst_n, .motor_en, .stall_cmd, .stall_in);
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic stop_test();
      if (err_total == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic look(input int n);
      cyc(n);
      #1;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge mclk);
      bus_wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a);
      @(posedge mclk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge mclk);
      bus_rd <= 1'b0;
      #1;
      rd_val = bus_rdata;
   endtask
   task automatic press(input logic up);
      @(posedge mclk);
      btn_up   <= up;
      btn_down <= !up;
      @(posedge mclk);
      btn_up   <= 1'b0;
      btn_down <= 1'b0;
      look(1);
   endtask
   task automatic hold(input int n);
      @(posedge mclk);
      btn_up   <= 1'b1;
      btn_down <= 1'b1;
      cyc(n);
      btn_up   <= 1'b0;
      btn_down <= 1'b0;
      #1;
   endtask
   task automatic start(input logic rev);
      @(posedge mclk);
      push_plate_rev <= rev;
      trigger_in     <= 1'b1;
      look(1);
   endtask
   task automatic release_trigger();
      @(posedge mclk);
      trigger_in <= 1'b0;
      look(6);
   endtask
   initial
   begin
      {bus_wr, bus_rd, trigger_in, push_plate_rev, brake_sig_in, undervolt_in} = '0;
      {overtemp_in, stall_cmd, mem_fail_in, btn_up, btn_down, rst_n} = '0;
      bus_addr = '0;
      bus_wdata = '0;
      err_total = 0;
      compares = 0;
      cyc(3);
      rst_n <= 1'b1;
      look(1);
      chk(disp_mode, DISP_NO_SLOW);
      reg_rd(ADDR_CTRL);
      chk(rd_val, 32'h1);
      reg_rd(8'h1c);
      chk(rd_val, 32'h0);
      start(1'b0);
      chk({run_relay, motor_en, speed_pct}, {2'h3, FULL_PCT});
      chk(reverse_relay, 1'b0);
      @(posedge mclk);
      trigger_in <= 1'b0;
      look(2);
      chk({run_relay, brake_relay}, 2'h1);
      look(4);
      chk(brake_relay, 1'b0);
      reg_wr(ADDR_CTRL, 32'h0);
      start(1'b0);
      look(2);
      chk(run_relay, 1'b0);
      release_trigger();
      reg_wr(ADDR_CTRL, 32'h1);
      // Bus write above range clamps, then panel walk through both menus
      reg_wr(ADDR_DURATION, 32'h7f);
      reg_rd(ADDR_DURATION);
      chk(rd_val, 32'h63);
      hold(20);
      chk({disp_mode, disp_value}, {DISP_DURATION_MENU, 7'h63});
      press(1'b1);
      chk(disp_value, 7'h63);
      press(1'b0);
      chk(disp_value, 7'h62);
      hold(10);
      chk({disp_mode, disp_value}, {DISP_SPEED_MENU, 7'h00});
      press(1'b0);
      chk(disp_value, 7'h00);
      press(1'b1);
      press(1'b1);
      chk(disp_value, 7'h02);
      hold(10);
      chk({disp_mode, disp_value}, {DISP_LEVEL, 7'h02});
      reg_rd(ADDR_LEVEL);
      chk(rd_val, 32'h2);
      // 98 tenths at 4 cycles each: 392 cycles of reduced speed
      start(1'b0);
      chk(speed_pct, 7'h25);
      look(385);
      chk(speed_pct, 7'h25);
      look(12);
      chk(speed_pct, FULL_PCT);
      release_trigger();
      for (int k = 0; k < 4; k++)
      begin
         start(1'b0);
         @(posedge mclk);
         {mem_fail_in, stall_cmd, overtemp_in, undervolt_in} <= 4'h1 << k;
         look(3);
         chk({disp_mode, run_relay}, {DISP_FAULT, 1'b0});
         chk(disp_value, {3'h0, FCODE[k]});
         @(posedge mclk);
         {mem_fail_in, stall_cmd, overtemp_in, undervolt_in, trigger_in} <= '0;
         look(40);
         chk(disp_mode, DISP_FAULT);
         look(12);
         chk(disp_mode, DISP_LEVEL);
      end
      start(1'b1);
      look(1);
      chk(reverse_relay, 1'b1);
      @(posedge mclk);
      push_plate_rev <= 1'b0;
      look(2);
      chk({disp_mode, run_relay}, {DISP_FAULT, 1'b0});
      chk(disp_value, 7'(PUSH_PLATE_CODE));
      look(60);
      chk(disp_value, 7'(PUSH_PLATE_CODE));
      @(posedge mclk);
      push_plate_rev <= 1'b1;
      look(3);
      chk(disp_mode, DISP_LEVEL);
      release_trigger();
      @(posedge mclk);
      brake_sig_in <= 1'b1;
      start(1'b0);
      look(60);
      chk({disp_mode, run_relay}, {DISP_FAULT, 1'b0});
      chk(disp_value, 7'(BRAKE_FAULT_CODE));
      @(posedge mclk);
      brake_sig_in <= 1'b0;
      trigger_in   <= 1'b0;
      look(3);
      chk(disp_mode, DISP_LEVEL);
      // Fault status is sticky but masked until enabled
      chk(irq, 1'b0);
      reg_rd(ADDR_IRQ_STAT);
      chk(rd_val[IRQ_FAULT], 1'b1);
      reg_wr(ADDR_IRQ_EN, 32'h1);
      look(1);
      chk(irq, 1'b1);
      reg_wr(ADDR_IRQ_CLR, 32'hf);
      look(1);
      chk(irq, 1'b0);
      stop_test();
   end
   initial
   begin
      cyc(5000);
      err_total++;
      stop_test();
   end
endmodule
